// File: rtl/emb_pkg.sv
// emb_pkg: shared constants and carrier types for the external memory bus sequencer
// assumes a single core clock domain standing in for the memory clock
package emb_pkg;
  localparam int          EMB_CE_SPACES      = 4;
  localparam int          EMB_CNT_W          = 4;
  localparam int          EMB_BURST_LEN      = 4;   // default incrementing burst length
  localparam int          EMB_CAS_LATENCY    = 3;   // sdram read column latency
  localparam int          EMB_HOLD_FLOAT_MIN = 2;   // memory clocks before bus floats
  localparam int          EMB_HOLD_DRIVE_MIN = 2;   // memory clocks before bus is driven again
  localparam int          EMB_HOLD_DRIVE_MAX = 7;
  localparam logic [3:0]  EMB_CE_IDLE        = 4'hf;
  localparam logic [3:0]  EMB_BE_IDLE        = 4'hf;
  localparam logic [2:0]  EMB_CTL_IDLE       = 3'h7;
  localparam logic [2:0]  EMB_CNT_RST        = 3'h0;

  // memory type of a chip-enable space
  typedef enum logic [1:0] {
    EMB_MT_ASYNC,
    EMB_MT_SBSRAM,
    EMB_MT_SDRAM
  } emb_mtype_t;

  // sdram commands encoded as {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    EMB_SD_NOP   = 3'h7,
    EMB_SD_READ  = 3'h5,
    EMB_SD_WRITE = 3'h4,
    EMB_SD_BANK_ACTIVATE_CMD  = 3'h3,
    EMB_SD_DEACTIVATE_BANK_CMD  = 3'h2,
    EMB_SD_REFRESH_CMD  = 3'h1,
    EMB_SD_MRS   = 3'h0
  } emb_sdcmd_t;

  // per-space timing set
  typedef struct packed {
    emb_mtype_t           mtype;
    logic [EMB_CNT_W-1:0] read_setup_count;
    logic [EMB_CNT_W-1:0] read_strobe_count;
    logic [EMB_CNT_W-1:0] read_hold_count;
    logic [EMB_CNT_W-1:0] write_setup_count;
    logic [EMB_CNT_W-1:0] write_strobe_count;
    logic [EMB_CNT_W-1:0] write_hold_count;
  } emb_space_cfg_t;

  // one user request
  typedef struct packed {
    logic        write;
    logic [1:0]  space;
    logic [19:0] word_address;
    logic [3:0]  byte_enable_n;
    logic [31:0] data;
    logic [2:0]  burst_len;   // words, 1..4; shorter cuts a burst short
    logic        sd_special;  // issue sd_cmd alone
    emb_sdcmd_t  sd_cmd;
  } emb_req_t;

  // shared bus pin group
  typedef struct packed {
    logic [3:0]  chip_enable_n;
    logic [3:0]  byte_enable_n;
    logic [19:0] word_address;
    logic [2:0]  ctl_n;       // {pin_a, pin_b, pin_c}
  } emb_pins_t;
endpackage : emb_pkg

// File: rtl/emb_sequencer.sv
// emb_sequencer: pin sequencing for async, sbsram and sdram cycles plus bus hold
// assumes requests are synchronous to core_clk, which also times the memory clock
// What this block does
// (R1) select signals valid read-setup clocks before read strobe falls
// (R2) select signals held read-hold clocks after read strobe rises
// (R3) write select setup and hold counts around write strobe
// (R4) setup, strobe, hold counts programmed separately per chip-enable space
// (R5) select group: chip enables, byte enables, address, output enable, write data
// (R6) async: shared pins are output enable, read strobe, write strobe
// (R7) sbsram uses memory burst counter, default incrementing four-word bursts
// (R8) other bursts cut short a burst, data keeps flowing
// (R9) sbsram: shared pins are address strobe, output enable, write enable
// (R10) sdram: shared pins are column strobe, write enable, row strobe
// (R11) sdram uses memory burst counter, default four-word incrementing bursts
// (R12) sdram reads use latency three; other commands also issued
// (R13) all outputs change on rising memory clock edge
// (R14) synchronous reads capture data on rising memory clock edge
// (R15) on hold request, float bus after two clocks, then acknowledge
// (R16) on release, drive bus within two to seven clocks, then deassert acknowledge
// (R17) pending transfers finish before acknowledge; idle bus acknowledges fast
// (R18) hold disable set defers granting the bus indefinitely
// (R19) master keeps hold request low a clock after acknowledge
// (R20) released bus: chip enables, byte enables, data, address, shared pins
// (R21) bus request output updates on rising memory clock edge
// (R22) ready input synchronised, acted on in the cycle sampled valid
// (R23) output memory clock follows both edges of memory clock input
// (R24) not-ready extends strobe by whole clocks before hold phase
// (R25) strobe active for programmed strobe count between setup and hold
`timescale 1ns/100ps
module emb_sequencer
  import emb_pkg::*;
#(
  parameter int BURST_LEN = EMB_BURST_LEN
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire logic                  mem_clock_in,
  input  wire emb_space_cfg_t [3:0]  space_cfg,
  input  wire logic                  hold_disable,
  input  wire logic                  req_valid,
  input  wire emb_req_t              req,
  output logic                       req_ready,
  output logic                       rd_valid,
  output logic [31:0]                rd_data,
  output logic                       mem_clock_out,
  output emb_pins_t                  pins_o,
  output logic [2:0]                 pins_oe_n,
  output logic [31:0]                mem_data_o,
  output logic                       mem_data_oe_n,
  input  wire logic [31:0]           mem_data_i,
  input  wire logic                  async_ready,
  input  wire logic                  hold_request_n,
  output logic                       hold_acknowledge_n,
  output logic                       bus_request_out
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_BURST, ST_SD_LAT, ST_SD_CMD,
    ST_FLOAT, ST_HELD, ST_RESUME
  } emb_state_t;

  emb_state_t           state_reg;
  emb_req_t             cur_reg;
  logic [EMB_CNT_W-1:0] cnt_reg;
  logic [2:0]           beat_reg;
  logic [2:0]           lat_reg;
  logic [2:0]           hcnt_reg;
  logic                 rdy_s1_reg;
  logic                 rdy_s2_reg;
  emb_space_cfg_t       cfg;
  logic                 hold_want;

  assign cfg       = space_cfg[cur_reg.space];
  assign hold_want = !hold_request_n && !hold_disable;  // (R18)

  // counts of zero still take one clock; keeps phase lengths well defined
  function automatic logic [EMB_CNT_W-1:0] emb_len(input logic [EMB_CNT_W-1:0] c);
    emb_len = (c == '0) ? EMB_CNT_W'(1) : c;
  endfunction : emb_len

  function automatic logic [3:0] emb_ce(input logic [1:0] s);
    emb_ce = ~(4'h1 << s);
  endfunction : emb_ce

  // output memory clock: registered copy of the memory clock input, both edges
  always_ff @(posedge core_clk) begin
    if (rst) mem_clock_out <= 1'b0;
    else if (clk_en) mem_clock_out <= mem_clock_in;  // (R23)
  end

  // ready synchroniser; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdy_s1_reg <= 1'b1;
      rdy_s2_reg <= 1'b1;
    end else if (clk_en) begin
      rdy_s1_reg <= async_ready;  // (R22)
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  // bus request flags a waiting transfer while the bus is lent out
  always_ff @(posedge core_clk) begin
    if (rst) bus_request_out <= 1'b0;
    else if (clk_en) bus_request_out <= req_valid && (state_reg == ST_HELD);  // (R21)
  end

  // main sequencer: phases, pins and data; all pins move on the rising edge  (R13)
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg          <= ST_IDLE;
      cur_reg            <= '0;
      cnt_reg            <= '0;
      beat_reg           <= EMB_CNT_RST;
      lat_reg            <= EMB_CNT_RST;
      hcnt_reg           <= EMB_CNT_RST;
      req_ready          <= 1'b0;
      rd_valid           <= 1'b0;
      rd_data            <= '0;
      pins_o             <= '{EMB_CE_IDLE, EMB_BE_IDLE, 20'h00000, EMB_CTL_IDLE};
      pins_oe_n          <= 3'h0;
      mem_data_o         <= '0;
      mem_data_oe_n      <= 1'b1;
      hold_acknowledge_n <= 1'b1;
    end else if (clk_en) begin
      req_ready <= 1'b0;
      rd_valid  <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          pins_o.chip_enable_n <= EMB_CE_IDLE;
          pins_o.ctl_n         <= EMB_CTL_IDLE;
          mem_data_oe_n        <= 1'b1;
          if (hold_want) begin  // (R17) idle bus: go straight to float
            hcnt_reg  <= EMB_CNT_RST;
            state_reg <= ST_FLOAT;
          end else if (req_valid && !req_ready) begin
            cur_reg   <= req;
            req_ready <= 1'b1;
            pins_o.chip_enable_n <= emb_ce(req.space);  // (R5)
            pins_o.byte_enable_n <= req.byte_enable_n;
            pins_o.word_address  <= req.word_address;
            mem_data_o           <= req.data;
            beat_reg             <= EMB_CNT_RST;
            unique case (space_cfg[req.space].mtype)
              EMB_MT_SBSRAM: begin
                // address strobe, output enable, write enable  (R9)
                pins_o.ctl_n  <= {1'b0, req.write, !req.write};  // (R7)
                mem_data_oe_n <= !req.write;
                lat_reg       <= 3'h2;
                state_reg     <= ST_BURST;
              end
              EMB_MT_SDRAM: begin
                // column strobe, write enable, row strobe  (R10)
                if (req.sd_special)
                  pins_o.ctl_n <= {req.sd_cmd[1], req.sd_cmd[0], req.sd_cmd[2]};  // (R12)
                else if (req.write)
                  pins_o.ctl_n <= {EMB_SD_WRITE[1], EMB_SD_WRITE[0], EMB_SD_WRITE[2]};
                else
                  pins_o.ctl_n <= {EMB_SD_READ[1], EMB_SD_READ[0], EMB_SD_READ[2]};
                mem_data_oe_n <= !(req.write && !req.sd_special);
                lat_reg       <= 3'(EMB_CAS_LATENCY);  // (R12)
                state_reg     <= req.sd_special ? ST_SD_CMD
                               : (req.write ? ST_BURST : ST_SD_LAT);  // (R11)
              end
              default: begin
                // output enable low for reads, strobes idle in setup  (R6)
                pins_o.ctl_n  <= {req.write, 1'b1, 1'b1};
                mem_data_oe_n <= !req.write;  // (R5)
                cnt_reg   <= emb_len(req.write ? space_cfg[req.space].write_setup_count
                                               : space_cfg[req.space].read_setup_count);  // (R4)
                state_reg <= ST_SETUP;
              end
            endcase
          end
        end
        ST_SETUP: begin  // (R1) (R3)
          if (cnt_reg == EMB_CNT_W'(1)) begin
            pins_o.ctl_n <= cur_reg.write ? 3'b110 : 3'b001;
            cnt_reg      <= emb_len(cur_reg.write ? cfg.write_strobe_count
                                                  : cfg.read_strobe_count);
            state_reg    <= ST_STROBE;
          end else cnt_reg <= cnt_reg - EMB_CNT_W'(1);
        end
        ST_STROBE: begin  // (R25)
          if (cnt_reg > EMB_CNT_W'(1)) cnt_reg <= cnt_reg - EMB_CNT_W'(1);
          else if (rdy_s2_reg) begin  // (R24) not ready stretches strobe
            if (!cur_reg.write) begin
              rd_data  <= mem_data_i;
              rd_valid <= 1'b1;
            end
            pins_o.ctl_n <= {cur_reg.write, 1'b1, 1'b1};
            cnt_reg      <= emb_len(cur_reg.write ? cfg.write_hold_count
                                                  : cfg.read_hold_count);
            state_reg    <= ST_HOLD;
          end
        end
        ST_HOLD: begin  // (R2) (R3)
          if (cnt_reg == EMB_CNT_W'(1)) begin
            // selects drop with the last hold clock, not one idle clock later
            pins_o.chip_enable_n <= EMB_CE_IDLE;
            pins_o.ctl_n         <= EMB_CTL_IDLE;
            mem_data_oe_n        <= 1'b1;
            state_reg            <= ST_IDLE;
          end else cnt_reg <= cnt_reg - EMB_CNT_W'(1);
        end
        ST_SD_LAT: begin
          pins_o.ctl_n <= EMB_CTL_IDLE;
          if (lat_reg == 3'h1) state_reg <= ST_BURST;
          else lat_reg <= lat_reg - 3'h1;
        end
        ST_BURST: begin  // (R8) short length cuts the burst, no gaps between beats
          if (space_cfg[cur_reg.space].mtype == EMB_MT_SBSRAM)
            pins_o.ctl_n <= {1'b1, cur_reg.write, !cur_reg.write};
          else pins_o.ctl_n <= EMB_CTL_IDLE;
          if (lat_reg != 3'h0 && cfg.mtype == EMB_MT_SBSRAM && !cur_reg.write) begin
            // pipelined sbsram: the first word stands two clocks after the address strobe
            lat_reg <= lat_reg - 3'h1;  // (R7)
          end else begin
            if (!cur_reg.write) begin
              rd_data  <= mem_data_i;  // (R14)
              rd_valid <= 1'b1;
            end
            if ({1'b0, beat_reg} + 4'h1 >= 4'(cur_reg.burst_len == 3'h0 ? BURST_LEN
                                                                     : cur_reg.burst_len)) begin
              pins_o.ctl_n <= EMB_CTL_IDLE;
              state_reg    <= ST_IDLE;
            end
            beat_reg <= beat_reg + 3'h1;
          end
        end
        ST_SD_CMD: begin
          pins_o.ctl_n <= EMB_CTL_IDLE;
          state_reg    <= ST_IDLE;
        end
        ST_FLOAT: begin  // (R15) float after two clocks, then acknowledge
          hcnt_reg <= hcnt_reg + 3'h1;
          if (hcnt_reg == 3'(EMB_HOLD_FLOAT_MIN - 1)) begin
            pins_oe_n     <= 3'h7;  // (R20)
            mem_data_oe_n <= 1'b1;
          end
          if (hcnt_reg == 3'(EMB_HOLD_FLOAT_MIN)) begin
            hold_acknowledge_n <= 1'b0;
            state_reg          <= ST_HELD;
          end
        end
        ST_HELD: begin  // (R19) master keeps request low past acknowledge
          hcnt_reg <= EMB_CNT_RST;
          if (hold_request_n) state_reg <= ST_RESUME;
        end
        ST_RESUME: begin  // (R16) drive at two clocks, acknowledge released after
          hcnt_reg <= hcnt_reg + 3'h1;
          if (hcnt_reg == 3'(EMB_HOLD_DRIVE_MIN - 2)) pins_oe_n <= 3'h0;
          if (hcnt_reg == 3'(EMB_HOLD_DRIVE_MIN - 1)) begin
            hold_acknowledge_n <= 1'b1;
            state_reg          <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // checks
  a_hold_float_first: assert property (@(posedge core_clk) disable iff (rst)
    $fell(hold_acknowledge_n) |-> pins_oe_n == 3'h7)  // (R15)
    else $error("acknowledge before bus floated");
  a_hold_drive_first: assert property (@(posedge core_clk) disable iff (rst)
    $rose(hold_acknowledge_n) |-> pins_oe_n == 3'h0)  // (R16)
    else $error("acknowledge released before bus driven");
  a_hold_min_delay: assert property (@(posedge core_clk) disable iff (rst)
    $fell(hold_acknowledge_n) |-> $past(state_reg, 2) == ST_FLOAT)  // (R15)
    else $error("hold acknowledged too early");
  a_hold_disabled: assert property (@(posedge core_clk) disable iff (rst)
    hold_disable && state_reg == ST_IDLE |=> state_reg != ST_FLOAT)  // (R18)
    else $error("bus granted while hold disabled");
  a_strobe_follows_setup: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == ST_STROBE && $past(state_reg) == ST_SETUP |->
    pins_o.chip_enable_n != EMB_CE_IDLE)  // (R1)
    else $error("strobe without selects");
  a_ready_stretch: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    state_reg == ST_STROBE && cnt_reg <= EMB_CNT_W'(1) && !rdy_s2_reg
    |=> state_reg == ST_STROBE)  // (R24)
    else $error("strobe ended while not ready");
  a_hold_selects: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == ST_HOLD |-> pins_o.ctl_n[1:0] == 2'b11
    && pins_o.chip_enable_n != EMB_CE_IDLE)  // (R2)
    else $error("selects dropped during hold");
  a_sd_latency: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    state_reg == ST_SD_LAT && $past(state_reg) == ST_IDLE |=> ##1 state_reg == ST_SD_LAT)  // (R12)
    else $error("sdram latency too short");
  c_async_read: cover property (@(posedge core_clk) state_reg == ST_HOLD && !cur_reg.write);
  c_burst_full: cover property (@(posedge core_clk) state_reg == ST_BURST && beat_reg == 3'h3);
  c_hold_grant: cover property (@(posedge core_clk) $fell(hold_acknowledge_n));

endmodule : emb_sequencer

// File: bench/emb_mem_model.sv
// emb_mem_model: word memory on the far side of the shared memory pins
// assumes pins change on core_clk rising edges; sdram selects the sdram reading of the pins
`timescale 1ns/100ps
module emb_mem_model
  import emb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        slow,
  input  wire logic        sdram,
  input  wire logic        sbsram,
  input  wire emb_pins_t   pins_o,
  input  wire logic [31:0] mem_data_o,
  input  wire logic        mem_data_oe_n,
  output logic [31:0]      mem_data_i,
  output logic             async_ready
);
  logic [31:0] mem [16];
  logic [2:0]  sd_cnt = 3'h0;
  logic [3:0]  sd_addr = 4'h0;
  logic [3:0]  sel_cnt = 4'h0;
  wire         sel = (pins_o.chip_enable_n != EMB_CE_IDLE);
  initial mem_data_i = 32'h5a5a_a5a5;
  // slow mode holds ready low for the first six selected clocks
  assign async_ready = !(slow && sel && sel_cnt < 4'h6);
  always @(posedge core_clk) begin
    sel_cnt <= sel ? sel_cnt + 4'(sel_cnt != 4'hf) : 4'h0;
  end
  // async write strobe stores the driven word
  always @(posedge core_clk) begin
    if (!sdram && sel && !pins_o.ctl_n[0] && !mem_data_oe_n) begin
      mem[pins_o.word_address[3:0]] <= mem_data_o;
    end
  end
  // a read command starts four beats, the first ready at the third edge after it
  always @(posedge core_clk) begin
    if (sd_cnt != 3'h0) begin
      sd_cnt <= (sd_cnt == 3'h5) ? 3'h0 : sd_cnt + 3'h1;
    end else if (sel && (sdram ? pins_o.ctl_n == 3'h3 : sbsram && pins_o.ctl_n == 3'h1)) begin
      // pipelined sbsram answers one clock sooner than the sdram column latency
      sd_cnt  <= sbsram ? 3'h2 : 3'h1;
      sd_addr <= pins_o.word_address[3:0];
    end
    // undriven lines toggle so a stale word never looks valid
    if (sd_cnt >= 3'h2) mem_data_i <= mem[sd_addr + {1'b0, sd_cnt} - 4'h2];
    else if (!sdram && sel && !pins_o.ctl_n[2]) mem_data_i <= mem[pins_o.word_address[3:0]];
    else mem_data_i <= ~mem_data_i;
  end
endmodule : emb_mem_model

// File: bench/test_external_memory_bus_sequencer.sv
// test_external_memory_bus_sequencer: directed scenarios for the pin sequencer
// assumes emb_mem_model answers reads; clk_en is held high throughout
`timescale 1ns/100ps
module test_external_memory_bus_sequencer;
  import emb_pkg::*;
  logic                 core_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 mem_clock_in = 1'b0;
  logic                 hold_disable = 1'b0;
  logic                 req_valid = 1'b0;
  logic                 hold_request_n = 1'b1;
  logic                 slow = 1'b0;
  logic                 sdram = 1'b0;
  logic                 sbsram = 1'b0;
  logic [2:0]           blen = 3'h0;
  logic                 prev_mci = 1'b0;
  logic                 past_ok = 1'b0;
  logic                 bad;
  emb_req_t             req = '0;
  emb_space_cfg_t [3:0] space_cfg;
  logic                 req_ready, rd_valid, mem_clock_out, mem_data_oe_n, async_ready;
  logic                 hold_acknowledge_n, bus_request_out;
  logic [31:0]          rd_data, mem_data_o, mem_data_i;
  logic [2:0]           pins_oe_n, first_ctl;
  emb_pins_t            pins_o;
  logic [31:0]          got [$];
  int                   error_cnt = 0;
  int                   comparisons = 0;
  int                   n_s, n_t, n_h, nf, na;

  emb_sequencer u_dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .mem_clock_in(mem_clock_in), .space_cfg(space_cfg), .hold_disable(hold_disable),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .mem_clock_out(mem_clock_out), .pins_o(pins_o),
    .pins_oe_n(pins_oe_n), .mem_data_o(mem_data_o), .mem_data_oe_n(mem_data_oe_n),
    .mem_data_i(mem_data_i), .async_ready(async_ready), .hold_request_n(hold_request_n),
    .hold_acknowledge_n(hold_acknowledge_n), .bus_request_out(bus_request_out));
  emb_mem_model u_mem (.core_clk(core_clk), .slow(slow), .sdram(sdram), .sbsram(sbsram),
    .pins_o(pins_o), .mem_data_o(mem_data_o), .mem_data_oe_n(mem_data_oe_n),
    .mem_data_i(mem_data_i), .async_ready(async_ready));

  always #2 core_clk = ~core_clk;
  // memory clock input at half the core rate; its copy must trail by one core clock
  always @(posedge core_clk) mem_clock_in <= ~mem_clock_in;
  always @(negedge core_clk) begin
    if (!rst && past_ok) check("mem_clock_out", 32'(mem_clock_out), 32'(prev_mci));
    past_ok = !rst;
    prev_mci = mem_clock_in;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // one request; counts setup, strobe and hold clocks while its chip enable is low
  task automatic xfer(input logic w, input logic [1:0] sp, input logic [19:0] a,
                      input logic [31:0] d, input logic sd_sp, input emb_sdcmd_t cmd);
    logic taken, seen_ce, seen_str, strobe;
    taken = 1'b0; seen_ce = 1'b0; seen_str = 1'b0; bad = 1'b0;
    n_s = 0; n_t = 0; n_h = 0;
    first_ctl = EMB_CTL_IDLE;
    got.delete();
    @(posedge core_clk);
    req <= '{w, sp, a, 4'h5, d, blen, sd_sp, cmd};
    req_valid <= 1'b1;
    for (int k = 0; k < 80; k++) begin
      @(negedge core_clk);
      if (req_ready === 1'b1) taken = 1'b1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
      if (pins_o.chip_enable_n[sp] === 1'b0) begin
        seen_ce = 1'b1;
        if (first_ctl == EMB_CTL_IDLE) first_ctl = pins_o.ctl_n;
        if (!sdram && (pins_o.word_address !== a || pins_o.byte_enable_n !== 4'h5)) bad = 1;
        if (!sdram && !w && pins_o.ctl_n[2] !== 1'b0) bad = 1'b1;
        if (!sdram && w && (mem_data_o !== d || mem_data_oe_n !== 1'b0)) bad = 1'b1;
        if (hold_acknowledge_n !== 1'b1) bad = 1'b1;
        strobe = w ? pins_o.ctl_n[0] : pins_o.ctl_n[1];
        if (!strobe) begin
          n_t++;
          seen_str = 1'b1;
        end else if (seen_str) n_h++;
        else n_s++;
      end else if (seen_ce && taken && (!sdram || sd_sp || got.size() == 4)) break;
      @(posedge core_clk);
      if (taken) req_valid <= 1'b0;
    end
  endtask : xfer

  // clocks until pins_oe_n shows oe_v and until the acknowledge shows ack_v
  task automatic wait_pair(input logic [2:0] oe_v, input logic ack_v);
    nf = 0;
    na = 0;
    for (int k = 1; k < 40 && na == 0; k++) begin
      @(negedge core_clk);
      if (nf == 0 && pins_oe_n === oe_v && (oe_v == 3'h0 || mem_data_oe_n === 1'b1)) nf = k;
      if (hold_acknowledge_n === ack_v) na = k;
    end
  endtask : wait_pair

  task automatic t_async();
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 2'h0, 20'h4 + 20'(i), 32'hc0de_0000 + 32'(i), 1'b0, EMB_SD_NOP);
      check("write counts", {n_s[7:0], n_t[7:0], n_h[7:0]}, 32'h020302);
      check("write selects stable", 32'(bad), 32'h0);
    end
    xfer(1'b0, 2'h1, 20'h5, 32'h0, 1'b0, EMB_SD_NOP);
    check("read counts", {n_s[7:0], n_t[7:0], n_h[7:0]}, 32'h030204);
    check("read selects stable", 32'(bad), 32'h0);
    check("read word", got.size() ? got[0] : 32'hx, 32'hc0de_0001);
    slow <= 1'b1;
    // long setup lets not-ready cross the two-flop synchroniser before the strobe ends
    xfer(1'b0, 2'h1, 20'h6, 32'h0, 1'b0, EMB_SD_NOP);
    check("not ready stretches", 32'(n_t > 2 && n_s == 3 && n_h == 4), 32'h1);
    check("slow read word", got.size() ? got[0] : 32'hx, 32'hc0de_0002);
    slow <= 1'b0;
    $display("test async done");
  endtask : t_async

  task automatic t_sdram();
    emb_sdcmd_t cmds [4] = '{EMB_SD_BANK_ACTIVATE_CMD, EMB_SD_DEACTIVATE_BANK_CMD, EMB_SD_REFRESH_CMD, EMB_SD_MRS};
    sdram <= 1'b1;
    foreach (cmds[i]) begin
      xfer(1'b0, 2'h2, 20'h0, 32'h0, 1'b1, cmds[i]);
      check("sdram command pins", 32'(first_ctl), 32'({cmds[i][1], cmds[i][0], cmds[i][2]}));
    end
    xfer(1'b0, 2'h2, 20'h4, 32'h0, 1'b0, EMB_SD_NOP);
    check("burst beats", 32'(got.size()), 32'h4);
    foreach (got[i]) check("burst word", got[i], 32'hc0de_0000 + 32'(i));
    sdram <= 1'b0;
    sbsram <= 1'b1;
    // full default burst, then one cut to two words
    for (int b = 0; b < 2; b++) begin
      blen <= (b != 0) ? 3'h2 : 3'h0;
      xfer(1'b0, 2'h3, 20'h4, 32'h0, 1'b0, EMB_SD_NOP);
      check("sbsram start pins", 32'(first_ctl), 32'h1);
      check("sbsram beats", 32'(got.size()), (b != 0) ? 32'h2 : 32'h4);
      foreach (got[i]) check("sbsram word", got[i], 32'hc0de_0000 + 32'(i));
    end
    sbsram <= 1'b0;
    blen <= 3'h0;
    $display("test sdram done");
  endtask : t_sdram

  task automatic t_hold();
    @(posedge core_clk);
    hold_request_n <= 1'b0;
    wait_pair(3'h7, 1'b0);
    check("float delay", 32'(nf >= EMB_HOLD_FLOAT_MIN), 32'h1);
    check("ack after float", 32'(na >= nf && na - nf <= 2 && nf > 0), 32'h1);
    @(posedge core_clk);
    req <= '{1'b1, 2'h0, 20'h8, 4'h0, 32'h0, 3'h0, 1'b0, EMB_SD_NOP};
    req_valid <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("request held off", 32'(req_ready), 32'h0);
    check("bus request shown", 32'(bus_request_out), 32'h1);
    @(posedge core_clk);
    hold_request_n <= 1'b1;
    wait_pair(3'h0, 1'b1);
    check("redrive delay", 32'(nf >= 2 && nf <= 7), 32'h1);
    check("ack after redrive", 32'(na >= nf && nf > 0), 32'h1);
    for (int k = 0; k < 20 && req_ready !== 1'b1; k++) @(posedge core_clk);
    req_valid <= 1'b0;
    repeat (20) @(posedge core_clk);
    fork
      xfer(1'b1, 2'h1, 20'h9, 32'h1234_5678, 1'b0, EMB_SD_NOP);
      begin
        repeat (2) @(posedge core_clk);
        hold_request_n <= 1'b0;
      end
    join
    check("no ack mid transfer", 32'(bad), 32'h0);
    wait_pair(3'h7, 1'b0);
    check("ack after transfer", 32'(na > 0), 32'h1);
    repeat (2) @(posedge core_clk);
    hold_request_n <= 1'b1;
    hold_disable <= 1'b1;
    wait_pair(3'h0, 1'b1);
    @(posedge core_clk);
    hold_request_n <= 1'b0;
    wait_pair(3'h7, 1'b0);
    check("hold disabled", 32'(na), 32'h0);
    @(posedge core_clk);
    hold_request_n <= 1'b1;
    @(posedge core_clk);
    hold_disable <= 1'b0;
    $display("test hold done");
  endtask : t_hold

  initial begin
    space_cfg[0] = '{EMB_MT_ASYNC, 4'h1, 4'h1, 4'h1, 4'h2, 4'h3, 4'h2};
    space_cfg[1] = '{EMB_MT_ASYNC, 4'h3, 4'h2, 4'h4, 4'h1, 4'h1, 4'h1};
    space_cfg[2] = '{EMB_MT_SDRAM, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
    space_cfg[3] = '{EMB_MT_SBSRAM, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_async();
    t_sdram();
    t_hold();
    end_sim();
  end

  // watchdog well beyond the few hundred clocks the scenarios need
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule : test_external_memory_bus_sequencer
